// ==== src/mmt_pkg.sv ====
// package: register map, field layout and encodings of the multi-mode timer unit
package mmt_pkg;

  // ----------------------------------------------------------------
  // register addresses (8-bit registers on a 4-bit address)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_WA_MODE = 4'h0; // wide_timer_a_mode_reg
  localparam logic [3:0] ADDR_WB_MODE = 4'h1; // wide_timer_b_mode_reg
  localparam logic [3:0] ADDR_NT_MODE = 4'h2; // narrow_timer_mode_reg
  localparam logic [3:0] ADDR_WA_LO = 4'h3;
  localparam logic [3:0] ADDR_WA_HI = 4'h4;
  localparam logic [3:0] ADDR_WB_LO = 4'h5;
  localparam logic [3:0] ADDR_WB_HI = 4'h6;
  localparam logic [3:0] ADDR_NT1 = 4'h7;
  localparam logic [3:0] ADDR_NT2 = 4'h8;
  localparam logic [3:0] ADDR_NT3 = 4'h9;
  localparam logic [3:0] ADDR_IRQ = 4'ha;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int WA_MODE_LSB = 0;  // wide a mode, 2 bits
  localparam int WA_POL_BIT = 2;   // phase a pin polarity
  localparam int WA_WCTL_BIT = 3;  // wide a write control
  localparam int STOP_BIT = 7;     // count stop, both wide mode registers
  localparam int WA_DIV_LSB = 0;   // wide a divider select, in wide b mode reg
  localparam int WB_DIV_LSB = 2;   // wide b divider select
  localparam int WB_MODE_LSB = 4;  // wide b mode, 2 bits
  localparam int WB_POL_BIT = 6;   // second event pin polarity
  localparam int NT_PWM_POL_BIT = 0;
  localparam int NT_PWM_EN_BIT = 1;
  localparam int NT2_SRC_BIT = 2;  // 1: count narrow timer 1 underflows
  localparam int NT3_SRC_BIT = 3;
  localparam int NT2_WCTL_BIT = 4;
  localparam int NT_DIV_LSB = 5;   // pre-divider ratio, 2 bits

  // interrupt request bit positions
  localparam int IRQ_WA = 0;
  localparam int IRQ_WB = 1;
  localparam int IRQ_PIN_A = 2;
  localparam int IRQ_PIN_B = 3;
  localparam int IRQ_NT1 = 4;
  localparam int IRQ_NT2 = 5;
  localparam int IRQ_NT3 = 6;
  localparam int IRQ_W = 7;

  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [15:0] WIDE_RST = 16'hffff;
  localparam logic [7:0] NARROW_RST = 8'hff;

  // divider masks: a tick fires when the masked prescaler bits are all ones
  localparam logic [7:0] WA_DIV_MASK [0:3] = '{8'h01, 8'h03, 8'h0f, 8'h7f};
  localparam logic [7:0] WB_DIV_MASK [0:3] = '{8'h01, 8'h07, 8'h1f, 8'h3f};
  localparam logic [7:0] NT_DIV_MASK [0:3] = '{8'h01, 8'h03, 8'h07, 8'h0f};

  typedef enum logic [1:0] {WA_TIMER, WA_BIPHASE, WA_EVENT, WA_PULSE} mmt_wa_mode_e;
  typedef enum logic [1:0] {WB_TIMER, WB_PERIOD, WB_EVENT, WB_HL} mmt_wb_mode_e;
  typedef enum logic [1:0] {NT_FREE, NT_PH2, NT_PH3} mmt_pwm_state_e;

  // register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } mmt_bus_req_s;

endpackage : mmt_pkg

// ==== src/mmt_timer_unit.sv ====
// multi-mode timer unit: two wide and three narrow down counters (wide a counts up and down in quadrature mode) with pwm
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/100ps

module mmt_timer_unit
  import mmt_pkg::*;
(
  input wire logic ref_clk_i,           // system clock, 10 MHz
  input wire logic rst_i,               // synchronous reset, active high
  input wire mmt_bus_req_s bus_req_i,   // register access request
  output logic [7:0] rdata_o,           // read data, cycle after read strobe
  input wire logic phase_a_event_pin_i, // phase a / first event pin
  input wire logic second_event_pin_i,  // second event pin
  input wire logic phase_b_input_pin_i, // phase b pin
  output logic pwm_o,                   // pwm waveform
  output logic [IRQ_W-1:0] irq_req_o    // interrupt request bits
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0] wa_mode_reg, wb_mode_reg, nt_mode_reg;
  logic [7:0] pre_cnt_reg;
  logic [2:0] pin_meta_reg, pin_sync_reg, pin_prev_reg;
  logic [2:0] rise, fall;
  logic tick_a, tick_b, tick_n;
  logic [15:0] wa_cnt_reg, wa_latch_reg, wb_cnt_reg, wb_latch_reg, wb_capt_reg;
  logic [7:0] wa_wtmp_reg, wa_rtmp_reg, wb_wtmp_reg, wb_rtmp_reg;
  logic [7:0] n1_cnt_reg, n1_latch_reg, n2_cnt_reg, n2_latch_reg;
  logic [7:0] n3_cnt_reg, n3_latch_reg;
  logic [IRQ_W-1:0] irq_reg, irq_set, irq_clr;
  logic [7:0] rdata_reg, rdata_next;
  logic pwm_reg;
  mmt_pwm_state_e pwm_state_reg;
  mmt_wa_mode_e wa_mode;
  mmt_wb_mode_e wb_mode;
  logic wa_up, wa_dn, wa_uf, wa_of, wa_load, wa_stop, wa_pol, wa_leave;
  logic wb_dn, wb_uf, wb_cap, wb_load, wb_stop, wb_pol, wb_edge;
  logic [15:0] wb_view;
  logic src2, src3, run2, run3, uf1, uf2, uf3, pwm_en, pwm_pol;
  logic wr, rd;

  assign wr = bus_req_i.we;
  assign rd = bus_req_i.re;

  // ----------------------------------------------------------------
  // mode registers
  // ----------------------------------------------------------------
  // software control of all three timer groups
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      wa_mode_reg <= MODE_RST;
      wb_mode_reg <= MODE_RST;
      nt_mode_reg <= MODE_RST;
    end
    else if (wr)
    begin
      if (bus_req_i.addr == ADDR_WA_MODE) wa_mode_reg <= bus_req_i.wdata;
      if (bus_req_i.addr == ADDR_WB_MODE) wb_mode_reg <= bus_req_i.wdata;
      if (bus_req_i.addr == ADDR_NT_MODE) nt_mode_reg <= bus_req_i.wdata;
    end
  end

  assign wa_mode = mmt_wa_mode_e'(wa_mode_reg[WA_MODE_LSB +: 2]);
  assign wb_mode = mmt_wb_mode_e'(wb_mode_reg[WB_MODE_LSB +: 2]);
  assign wa_stop = wa_mode_reg[STOP_BIT];
  assign wb_stop = wb_mode_reg[STOP_BIT];
  assign wa_pol = wa_mode_reg[WA_POL_BIT];
  assign wb_pol = wb_mode_reg[WB_POL_BIT];
  assign pwm_en = nt_mode_reg[NT_PWM_EN_BIT];
  assign pwm_pol = nt_mode_reg[NT_PWM_POL_BIT];

  // ----------------------------------------------------------------
  // clock dividers
  // ----------------------------------------------------------------
  // one free prescaler; all divided ticks are one-cycle pulses from it
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i) pre_cnt_reg <= 8'h00;
    else pre_cnt_reg <= pre_cnt_reg + 8'h01;
  end

  assign tick_a = (pre_cnt_reg & WA_DIV_MASK[wb_mode_reg[WA_DIV_LSB +: 2]])
                  == WA_DIV_MASK[wb_mode_reg[WA_DIV_LSB +: 2]];
  assign tick_b = (pre_cnt_reg & WB_DIV_MASK[wb_mode_reg[WB_DIV_LSB +: 2]])
                  == WB_DIV_MASK[wb_mode_reg[WB_DIV_LSB +: 2]];
  // shared pre-divider of the narrow timers
  assign tick_n = (pre_cnt_reg & NT_DIV_MASK[nt_mode_reg[NT_DIV_LSB +: 2]])
                  == NT_DIV_MASK[nt_mode_reg[NT_DIV_LSB +: 2]];

  // ----------------------------------------------------------------
  // pin synchronisers: bit 0 phase a, bit 1 second pin, bit 2 phase b
  // ----------------------------------------------------------------
  // meta stage is read only by the sync stage, so each edge counts once
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      pin_meta_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
      pin_prev_reg <= 3'h0;
    end
    else
    begin
      pin_meta_reg <= {phase_b_input_pin_i, second_event_pin_i, phase_a_event_pin_i};
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  assign rise = pin_sync_reg & ~pin_prev_reg;
  assign fall = ~pin_sync_reg & pin_prev_reg;

  // ----------------------------------------------------------------
  // wide timer a
  // ----------------------------------------------------------------
  // count direction per mode; phase b edges win if both pins move at once
  always_comb
  begin
    wa_up = 1'b0;
    wa_dn = 1'b0;
    case (wa_mode)
      WA_TIMER: wa_dn = tick_a;
      WA_BIPHASE:
      begin
        if (rise[2] | fall[2])
        begin
          wa_up = (rise[2] & ~pin_sync_reg[0]) | (fall[2] & pin_sync_reg[0]);
          wa_dn = (rise[2] & pin_sync_reg[0]) | (fall[2] & ~pin_sync_reg[0]);
        end
        else
        begin
          wa_up = (rise[0] & pin_sync_reg[2]) | (fall[0] & ~pin_sync_reg[2]);
          wa_dn = (rise[0] & ~pin_sync_reg[2]) | (fall[0] & pin_sync_reg[2]);
        end
      end
      WA_EVENT: wa_dn = wa_pol ? fall[0] : rise[0];
      WA_PULSE: wa_dn = tick_a & (pin_sync_reg[0] == wa_pol);
      default: wa_dn = 1'b0;
    endcase
    if (wa_stop)
    begin
      wa_up = 1'b0;
      wa_dn = 1'b0;
    end
  end

  assign wa_uf = wa_dn & (wa_cnt_reg == 16'h0000);
  assign wa_of = wa_up & (wa_cnt_reg == 16'hffff);
  assign wa_load = wr & (bus_req_i.addr == ADDR_WA_HI) & ~wa_mode_reg[WA_WCTL_BIT];
  assign wa_leave = (wa_mode == WA_PULSE) & (wa_pol ? fall[0] : rise[0]);

  // latch takes the high byte with the buffered low byte
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      wa_wtmp_reg <= 8'h00;
      wa_latch_reg <= WIDE_RST;
    end
    else if (wr && bus_req_i.addr == ADDR_WA_LO) wa_wtmp_reg <= bus_req_i.wdata;
    else if (wr && bus_req_i.addr == ADDR_WA_HI)
      wa_latch_reg <= {bus_req_i.wdata, wa_wtmp_reg};
  end

  // quadrature wraps freely; other modes reload on underflow
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i) wa_cnt_reg <= WIDE_RST;
    else if (wa_load) wa_cnt_reg <= {bus_req_i.wdata, wa_wtmp_reg};
    else if (wa_uf && wa_mode != WA_BIPHASE) wa_cnt_reg <= wa_latch_reg;
    else if (wa_dn) wa_cnt_reg <= wa_cnt_reg - 16'h0001;
    else if (wa_up) wa_cnt_reg <= wa_cnt_reg + 16'h0001;
  end

  // ----------------------------------------------------------------
  // wide timer b
  // ----------------------------------------------------------------
  // capture edges: chosen polarity in period mode, both in high/low mode
  always_comb
  begin
    wb_edge = 1'b0;
    wb_dn = tick_b;
    case (wb_mode)
      WB_TIMER: wb_edge = 1'b0;
      WB_PERIOD: wb_edge = wb_pol ? rise[1] : fall[1];
      WB_EVENT: wb_dn = wb_pol ? fall[1] : rise[1];
      WB_HL: wb_edge = rise[1] | fall[1];
      default: wb_edge = 1'b0;
    endcase
  end

  assign wb_cap = wb_edge & ~wb_stop;
  assign wb_uf = wb_dn & ~wb_stop & ~wb_cap & (wb_cnt_reg == 16'h0000);
  assign wb_load = wr & (bus_req_i.addr == ADDR_WB_HI);
  assign wb_view = (wb_mode == WB_PERIOD || wb_mode == WB_HL) ? wb_capt_reg : wb_cnt_reg;

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      wb_wtmp_reg <= 8'h00;
      wb_latch_reg <= WIDE_RST;
    end
    else if (wr && bus_req_i.addr == ADDR_WB_LO) wb_wtmp_reg <= bus_req_i.wdata;
    else if (wb_load) wb_latch_reg <= {bus_req_i.wdata, wb_wtmp_reg};
  end

  // capture and reload share the edge cycle; a tick in that cycle is not counted
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      wb_cnt_reg <= WIDE_RST;
      wb_capt_reg <= 16'h0000;
    end
    else if (wb_load) wb_cnt_reg <= {bus_req_i.wdata, wb_wtmp_reg};
    else if (wb_cap)
    begin
      wb_capt_reg <= wb_cnt_reg;
      wb_cnt_reg <= wb_latch_reg;
    end
    else if (wb_uf) wb_cnt_reg <= wb_latch_reg;
    else if (wb_dn && !wb_stop) wb_cnt_reg <= wb_cnt_reg - 16'h0001;
  end

  // ----------------------------------------------------------------
  // narrow timers and pwm
  // ----------------------------------------------------------------
  assign src2 = nt_mode_reg[NT2_SRC_BIT] ? uf1 : tick_n;
  assign src3 = nt_mode_reg[NT3_SRC_BIT] ? uf1 : tick_n;
  assign run2 = (pwm_state_reg != NT_PH3);
  assign run3 = (pwm_state_reg != NT_PH2);
  assign uf1 = tick_n & (n1_cnt_reg == 8'h00);
  assign uf2 = src2 & run2 & (n2_cnt_reg == 8'h00);
  assign uf3 = src3 & run3 & (n3_cnt_reg == 8'h00);

  // narrow timer 1: write loads both
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      n1_cnt_reg <= NARROW_RST;
      n1_latch_reg <= NARROW_RST;
    end
    else if (wr && bus_req_i.addr == ADDR_NT1)
    begin
      n1_cnt_reg <= bus_req_i.wdata;
      n1_latch_reg <= bus_req_i.wdata;
    end
    else if (uf1) n1_cnt_reg <= n1_latch_reg;
    else if (tick_n) n1_cnt_reg <= n1_cnt_reg - 8'h01;
  end

  // narrow timer 2: a deferred write reaches the counter at underflow
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      n2_cnt_reg <= NARROW_RST;
      n2_latch_reg <= NARROW_RST;
    end
    else
    begin
      if (wr && bus_req_i.addr == ADDR_NT2) n2_latch_reg <= bus_req_i.wdata;
      if (wr && bus_req_i.addr == ADDR_NT2 && !nt_mode_reg[NT2_WCTL_BIT])
        n2_cnt_reg <= bus_req_i.wdata;
      else if (uf2) n2_cnt_reg <= n2_latch_reg;
      else if (src2 && run2) n2_cnt_reg <= n2_cnt_reg - 8'h01;
    end
  end

  // narrow timer 3
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      n3_cnt_reg <= NARROW_RST;
      n3_latch_reg <= NARROW_RST;
    end
    else if (wr && bus_req_i.addr == ADDR_NT3)
    begin
      n3_cnt_reg <= bus_req_i.wdata;
      n3_latch_reg <= bus_req_i.wdata;
    end
    else if (uf3) n3_cnt_reg <= n3_latch_reg;
    else if (src3 && run3) n3_cnt_reg <= n3_cnt_reg - 8'h01;
  end

  // pwm sequencer: phase 2 then phase 3, output toggles at each hand-over
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      pwm_state_reg <= NT_FREE;
      pwm_reg <= 1'b0;
    end
    else
    begin
      case (pwm_state_reg)
        NT_FREE:
          if (pwm_en)
          begin
            pwm_state_reg <= NT_PH2;
            pwm_reg <= ~pwm_pol;
          end
        NT_PH2:
          if (!pwm_en)
          begin
            pwm_state_reg <= NT_FREE;
            pwm_reg <= 1'b0;
          end
          else if (uf2)
          begin
            pwm_state_reg <= NT_PH3;
            pwm_reg <= ~pwm_reg;
          end
        NT_PH3:
          if (!pwm_en)
          begin
            pwm_state_reg <= NT_FREE;
            pwm_reg <= 1'b0;
          end
          else if (uf3)
          begin
            pwm_state_reg <= NT_PH2;
            pwm_reg <= ~pwm_reg;
          end
        default:
        begin
          pwm_state_reg <= NT_FREE;
          pwm_reg <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // interrupt request bits and register reads
  // ----------------------------------------------------------------
  always_comb
  begin
    irq_set = '0;
    irq_set[IRQ_WA] = wa_uf | wa_of;
    irq_set[IRQ_WB] = wb_uf;
    irq_set[IRQ_PIN_A] = wa_leave;
    irq_set[IRQ_PIN_B] = wb_cap;
    irq_set[IRQ_NT1] = uf1;
    irq_set[IRQ_NT2] = uf2;
    irq_set[IRQ_NT3] = uf3;
    irq_clr = (wr && bus_req_i.addr == ADDR_IRQ) ? bus_req_i.wdata[IRQ_W-1:0] : '0;
  end

  // write one to clear; a new event in the clear cycle wins
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i) irq_reg <= '0;
    else irq_reg <= (irq_reg & ~irq_clr) | irq_set;
  end

  // reading a high byte freezes the low byte for the following read
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      wa_rtmp_reg <= 8'h00;
      wb_rtmp_reg <= 8'h00;
    end
    else if (rd)
    begin
      if (bus_req_i.addr == ADDR_WA_HI) wa_rtmp_reg <= wa_cnt_reg[7:0];
      if (bus_req_i.addr == ADDR_WB_HI) wb_rtmp_reg <= wb_view[7:0];
    end
  end

  always_comb
  begin
    case (bus_req_i.addr)
      ADDR_WA_MODE: rdata_next = wa_mode_reg;
      ADDR_WB_MODE: rdata_next = wb_mode_reg;
      ADDR_NT_MODE: rdata_next = nt_mode_reg;
      ADDR_WA_LO: rdata_next = wa_rtmp_reg;
      ADDR_WA_HI: rdata_next = wa_cnt_reg[15:8];
      ADDR_WB_LO: rdata_next = wb_rtmp_reg;
      ADDR_WB_HI: rdata_next = wb_view[15:8];
      ADDR_NT1: rdata_next = n1_cnt_reg;
      ADDR_NT2: rdata_next = n2_cnt_reg;
      ADDR_NT3: rdata_next = n3_cnt_reg;
      ADDR_IRQ: rdata_next = {1'b0, irq_reg};
      default: rdata_next = 8'h00;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i) rdata_reg <= 8'h00;
    else rdata_reg <= rd ? rdata_next : 8'h00;
  end

  assign rdata_o = rdata_reg;
  assign pwm_o = pwm_reg;
  assign irq_req_o = irq_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  quad_up_a: assert property (wa_mode == WA_BIPHASE && !wa_stop && rise[2]
    && !pin_sync_reg[0] && wa_cnt_reg != 16'hffff && !wa_load
    |=> wa_cnt_reg == $past(wa_cnt_reg) + 16'h0001) else $error("quadrature up count wrong");
  quad_wrap_a: assert property (wa_mode == WA_BIPHASE && wa_of && !wa_load
    |=> wa_cnt_reg == 16'h0000 && irq_reg[IRQ_WA]) else $error("quadrature wrap wrong");
  event_b_a: assert property (wb_mode == WB_EVENT && !wb_stop && rise[1] && !wb_pol
    && wb_cnt_reg != 16'h0000 && !wb_load
    |=> wb_cnt_reg == $past(wb_cnt_reg) - 16'h0001) else $error("event count b wrong");
  event_reload_a: assert property (wa_mode == WA_EVENT && wa_uf && !wa_load
    |=> wa_cnt_reg == $past(wa_latch_reg) && irq_reg[IRQ_WA]) else $error("event reload wrong");
  edge_pol_a: assert property (wa_mode == WA_EVENT && !(wa_pol ? fall[0] : rise[0])
    && !wa_load |=> $stable(wa_cnt_reg)) else $error("wrong edge counted");
  pulse_gate_a: assert property (wa_mode == WA_PULSE && pin_sync_reg[0] != wa_pol
    && !wa_load |=> $stable(wa_cnt_reg)) else $error("pulse count outside level");
  width_end_a: assert property (wa_leave |=> irq_reg[IRQ_PIN_A])
    else $error("width end request missing");
  period_cap_a: assert property (wb_cap && !wb_load
    |=> wb_capt_reg == $past(wb_cnt_reg) && wb_cnt_reg == $past(wb_latch_reg)
    && irq_reg[IRQ_PIN_B]) else $error("capture wrong");
  hl_read_a: assert property (rd && bus_req_i.addr == ADDR_WB_HI && wb_mode == WB_HL
    |=> rdata_o == $past(wb_capt_reg[15:8])) else $error("high/low read not captured");
  nt1_write_a: assert property (wr && bus_req_i.addr == ADDR_NT1
    |=> n1_cnt_reg == $past(bus_req_i.wdata) && n1_latch_reg == $past(bus_req_i.wdata))
    else $error("narrow 1 write wrong");
  nt2_defer_a: assert property (wr && bus_req_i.addr == ADDR_NT2
    && nt_mode_reg[NT2_WCTL_BIT] && !uf2 && !(src2 && run2)
    |=> $stable(n2_cnt_reg) && n2_latch_reg == $past(bus_req_i.wdata))
    else $error("deferred write touched counter");
  pwm_hand_a: assert property (pwm_state_reg == NT_PH2 && pwm_en && uf2
    |=> pwm_state_reg == NT_PH3 && pwm_o != $past(pwm_o)) else $error("pwm hand-over wrong");
  pwm_start_a: assert property (pwm_state_reg == NT_FREE && pwm_en
    |=> pwm_o == !$past(pwm_pol)) else $error("pwm start level wrong");
  stop_hold_a: assert property (wa_stop && !wa_load |=> $stable(wa_cnt_reg))
    else $error("stopped timer moved");

endmodule : mmt_timer_unit

// ==== testbench/mmt_pin_model.sv ====
// pin model: drives the external event and phase pins of the timer unit
`timescale 1ns/100ps
module mmt_pin_model (
  input wire logic ref_clk_i, // system clock
  output logic pin_a_o,       // phase a / first event pin
  output logic pin_b_o,       // phase b pin
  output logic pin_c_o        // second event pin
);
  // ----------------------------------------------------------------
  // pulse generator
  // ----------------------------------------------------------------
  // pins idle low, as a quiet encoder or sensor line would
  initial
  begin
    pin_a_o = 1'b0;
    pin_b_o = 1'b0;
    pin_c_o = 1'b0;
  end
  // each level held 6 clocks so the synchroniser sees every edge once
  // sel 0 phase a, 1 second pin, 2 quadrature: phase b then phase a, counting up
  task automatic pulse(input int sel, input int n);
    for (int i = 0; i < 2 * n; i++)
    begin
      @(posedge ref_clk_i);
      if (sel == 0 || (sel == 2 && i % 2 == 1)) pin_a_o <= ~pin_a_o;
      else if (sel == 1) pin_c_o <= ~pin_c_o;
      else pin_b_o <= ~pin_b_o;
      repeat (5) @(posedge ref_clk_i);
    end
  endtask : pulse
endmodule : mmt_pin_model

// ==== testbench/tb_multi_mode_timer_unit.sv ====
// testbench: register bus scenarios for the multi-mode timer unit
`timescale 1ns/100ps
module tb_multi_mode_timer_unit;
  import mmt_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  mmt_bus_req_s bus_req = '0;
  logic [7:0] rdata;
  logic pa, pb, pc, pwm;
  logic [IRQ_W-1:0] irq;
  int n_fail = 0;
  int tests_run = 0;
  logic [15:0] v;
  // ----------------------------------------------------------------
  // clock, design and pin model
  // ----------------------------------------------------------------
  initial
  begin
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  mmt_timer_unit DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus_req_i(bus_req),
    .rdata_o(rdata), .phase_a_event_pin_i(pa), .second_event_pin_i(pc),
    .phase_b_input_pin_i(pb), .pwm_o(pwm), .irq_req_o(irq));
  mmt_pin_model PM (.ref_clk_i(ref_clk_i), .pin_a_o(pa), .pin_b_o(pb), .pin_c_o(pc));
  // ----------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    bus_req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge ref_clk_i);
    bus_req.we <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    bus_req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge ref_clk_i);
    bus_req.re <= 1'b0;
    #1 d = rdata;
  endtask : rd
  // counts clocks until pwm shows the wanted level, looked at 1 ns after each edge
  task automatic wait_pwm(input logic lvl, output int c);
    c = 0;
    while (pwm !== lvl && c < 600)
    begin
      @(posedge ref_clk_i);
      #1 c++;
    end
  endtask : wait_pwm
  // high byte first so the low byte comes from the snapshot
  task automatic rd16(input logic [3:0] hi, output logic [15:0] d);
    rd(hi, d[15:8]);
    rd(hi - 4'h1, d[7:0]);
  endtask : rd16
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_event_a;
    wr(ADDR_WA_MODE, 8'h02);
    wr(ADDR_WA_LO, 8'h10);
    wr(ADDR_WA_HI, 8'h00);
    PM.pulse(0, 3);
    rd16(ADDR_WA_HI, v);
    chk(v, 16'h000d, "wide a event count");
    $display("test event_a done");
  endtask : t_event_a
  task automatic t_stop_b;
    wr(ADDR_WB_MODE, 8'ha0);
    // timer mode has been counting since reset, so start from a known value
    wr(ADDR_WB_LO, 8'hff);
    wr(ADDR_WB_HI, 8'hff);
    PM.pulse(1, 2);
    rd16(ADDR_WB_HI, v);
    chk(v, 16'hffff, "wide b counted while stopped");
    wr(ADDR_WB_MODE, 8'h20);
    PM.pulse(1, 2);
    rd16(ADDR_WB_HI, v);
    chk(v, 16'hfffd, "wide b event count");
    $display("test stop_b done");
  endtask : t_stop_b
  task automatic t_narrow1;
    int k;
    wr(ADDR_NT1, 8'h03);
    wr(ADDR_IRQ, 8'h10);
    #1 chk(16'(irq[IRQ_NT1]), 16'h0000, "narrow 1 request early");
    k = 0;
    while (irq[IRQ_NT1] !== 1'b1 && k < 40)
    begin
      @(posedge ref_clk_i);
      k++;
    end
    chk(16'(irq[IRQ_NT1]), 16'h0001, "narrow 1 underflow request");
    rd(4'hb, v[7:0]);
    chk(16'(v[7:0]), 16'h0000, "unmapped read");
    $display("test narrow1 done");
  endtask : t_narrow1
  task automatic t_quad;
    wr(ADDR_WA_MODE, 8'h01);
    wr(ADDR_WA_LO, 8'hfe);
    wr(ADDR_WA_HI, 8'hff);
    wr(ADDR_IRQ, 8'h01);
    PM.pulse(2, 2);
    rd16(ADDR_WA_HI, v);
    chk(v, 16'h0002, "quadrature up count");
    chk(16'(irq[IRQ_WA]), 16'h0001, "quadrature wrap request");
    $display("test quad done");
  endtask : t_quad
  // active-high pulse of 6 clocks gives exactly 3 ticks of the divide-by-2 source
  task automatic t_pulse;
    wr(ADDR_WA_MODE, 8'h07);
    wr(ADDR_WA_LO, 8'h00);
    wr(ADDR_WA_HI, 8'h01);
    wr(ADDR_IRQ, 8'h04);
    PM.pulse(0, 1);
    rd16(ADDR_WA_HI, v);
    chk(v, 16'h00fd, "pulse width count");
    chk(16'(irq[IRQ_PIN_A]), 16'h0001, "pulse end request");
    $display("test pulse done");
  endtask : t_pulse
  // falling edge acts 10 edges after the load; 9 edges count, 4 or 5 of them ticks
  task automatic t_period;
    logic [15:0] w;
    wr(ADDR_WB_MODE, 8'h10);
    wr(ADDR_IRQ, 8'h08);
    wr(ADDR_WB_LO, 8'h00);
    wr(ADDR_WB_HI, 8'h10);
    PM.pulse(1, 1);
    rd16(ADDR_WB_HI, v);
    chk(16'(v inside {16'h0ffb, 16'h0ffc}), 16'h0001, "period capture");
    repeat (20) @(posedge ref_clk_i);
    rd16(ADDR_WB_HI, w);
    chk(w, v, "capture read moved");
    chk(16'(irq[IRQ_PIN_B]), 16'h0001, "period edge request");
    $display("test period done");
  endtask : t_period
  // polarity 0: high for 2+1 ticks of narrow 2, low for 4+1 of narrow 3, 2 clocks each
  task automatic t_pwm;
    int c;
    wr(ADDR_NT2, 8'h02);
    wr(ADDR_NT3, 8'h04);
    wr(ADDR_NT_MODE, 8'h02);
    wait_pwm(1'b1, c);
    chk(16'(pwm), 16'h0001, "pwm start level");
    wait_pwm(1'b0, c);
    wait_pwm(1'b1, c);
    wait_pwm(1'b0, c);
    chk(16'(c), 16'h0006, "pwm high time");
    wait_pwm(1'b1, c);
    chk(16'(c), 16'h000a, "pwm low time");
    $display("test pwm done");
  endtask : t_pwm
  // ----------------------------------------------------------------
  // main sequence, watchdog and verdict
  // ----------------------------------------------------------------
  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  initial
  begin
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    #1 chk(16'(irq), 16'h0000, "requests after reset");
    t_event_a();
    t_stop_b();
    t_narrow1();
    t_quad();
    t_pulse();
    t_period();
    t_pwm();
    end_sim();
  end
  // the scenarios need well under 3000 cycles
  initial
  begin
    repeat (5000) @(posedge ref_clk_i);
    n_fail++;
    end_sim();
  end
endmodule : tb_multi_mode_timer_unit
